// ### logic/ldo_mode_pkg.sv
// Package for the four-channel regulator power-mode decoder.
// Assumes a 32-bit AXI4-Lite register bus on a single 25 MHz clock.
package ldo_mode_pkg;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   // Registers are word spaced: the byte address is four times the index.
   localparam int         addr_width       = 10;
   localparam logic [7:0] power_mode_index = 8'h99;
   localparam logic [7:0] source_index     = 8'h01;
   localparam logic [7:0] status_index     = 8'h02;
   localparam logic [9:0] power_mode_addr  = {power_mode_index, 2'h0};
   localparam logic [9:0] source_addr      = {source_index, 2'h0};
   localparam logic [9:0] status_addr      = {status_index, 2'h0};

   // -----------------------------------------------------------------
   // Field layout and reset values
   // -----------------------------------------------------------------
   localparam int         channels        = 4;
   localparam int         mode_width      = 2;
   localparam logic [7:0] power_mode_reset = 8'h00;
   localparam logic [7:0] source_reset     = 8'h00;

   // Bus response codes.
   localparam logic [1:0] resp_okay   = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;

   // -----------------------------------------------------------------
   // Field encodings
   // -----------------------------------------------------------------
   localparam logic [1:0] mode_off        = 2'h0;
   localparam logic [1:0] mode_group_lp   = 2'h1;
   localparam logic [1:0] mode_low_power  = 2'h2;
   localparam logic [1:0] mode_normal     = 2'h3;
   localparam logic [1:0] source_register = 2'h3;

   // Control levels of one regulator.
   typedef struct packed {
      logic on;
      logic low_power;
   } reg_ctrl_t;

endpackage

// ### logic/ldo_power_mode_decode.sv
// Power-mode decoder for regulator channels 4 to 7 with AXI4-Lite regs.
// Assumes sequencer enables and low-power signal arrive from pins.
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.

// Notes on behaviour
// - One byte holds four 2-bit mode fields.
// - Source select 0b11 picks register-driven interpretation.
// - Mode 0b00 always turns regulator off.
// - Direct 0b01 follows global low-power signal.
// - Direct 0b10 forces low-power on.
// - Direct 0b11 forces normal mode on.
// - Sequenced modes off while sequencer disabled.
// - Sequenced 0b01 on, low-power follows global.
// - Sequenced 0b10 on in low-power mode.
// - Sequenced 0b11 on in normal mode.
module ldo_power_mode_decode (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address and data
   input  wire logic [9:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [9:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Sequencer enables (index 0 is channel 4) and global low-power
   input  wire logic [3:0]  sequencer_enable,
   input  wire logic        global_low_power,
   // Regulator control levels (index 0 is channel 4)
   output logic [3:0]       regulator_on,
   output logic [3:0]       regulator_low_power
);

   // ------------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------------
   logic [7:0]  power_mode_control;
   logic [7:0]  regulator_sequencer_source_select;
   logic [9:0]  aw_addr;
   logic        aw_held;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        w_held;
   logic [3:0]  seq_stable;
   logic        glp_stable;
   logic [3:0]  next_on;
   logic [3:0]  next_low_power;

   // ------------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------------

   // Sequencer enables: one filter bit per channel, index 0 is channel 4.
   level_filter #(
      .width (ldo_mode_pkg::channels)
   ) u_level_filter_seq (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .raw      (sequencer_enable),
      .filtered (seq_stable)
   );

   // The global low-power level takes the same path, so a change to it
   // and to an enable made together reach the decoder on the same edge.
   level_filter #(
      .width (1)
   ) u_level_filter_glp (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .raw      (global_low_power),
      .filtered (glp_stable)
   );

   // ------------------------------------------------------------------
   // AXI4-Lite write path
   // ------------------------------------------------------------------

   // Address and data are caught separately, in either order.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= 10'h000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (aw_held && w_held && !s_axi_bvalid) begin
         aw_held <= 1'b0;
      end
   end

   // Write data holding register.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (aw_held && w_held && !s_axi_bvalid) begin
         w_held <= 1'b0;
      end
   end

   // Ready is high while the slot is free and no response is pending.
   // Ready is registered, so a beat taken on this edge closes the slot
   // before the next beat can be sampled.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held && !s_axi_bvalid &&
                          !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !w_held && !s_axi_bvalid &&
                          !(s_axi_wvalid && s_axi_wready);
      end
   end

   // Commit the write and raise the response once both halves are in.
   // A write to the status word is answered OKAY and dropped; an unmapped
   // address is answered SLVERR so that a wrong pointer shows up at once.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         power_mode_control <= ldo_mode_pkg::power_mode_reset;
         regulator_sequencer_source_select <= ldo_mode_pkg::source_reset;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= ldo_mode_pkg::resp_okay;
      end else if (aw_held && w_held && !s_axi_bvalid) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= ldo_mode_pkg::resp_okay;
         if (aw_addr[9:2] == ldo_mode_pkg::power_mode_index) begin
            if (w_strb[0]) begin
               power_mode_control <= w_data[7:0];
            end
         end else if (aw_addr[9:2] == ldo_mode_pkg::source_index) begin
            if (w_strb[0]) begin
               regulator_sequencer_source_select <= w_data[7:0];
            end
         end else if (aw_addr[9:2] == ldo_mode_pkg::status_index) begin
            s_axi_bresp <= ldo_mode_pkg::resp_okay; // Read-only, ignored.
         end else begin
            s_axi_bresp <= ldo_mode_pkg::resp_slverr;
         end
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // AXI4-Lite read path
   // ------------------------------------------------------------------

   // Address taken, data returned on the following edge.
   // Only one read is in flight: the address side stays closed until the
   // data have been accepted.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= ldo_mode_pkg::resp_okay;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= ldo_mode_pkg::resp_okay;
         if (s_axi_araddr[9:2] == ldo_mode_pkg::power_mode_index) begin
            s_axi_rdata <= {24'h00_0000, power_mode_control};
         end else if (s_axi_araddr[9:2] ==
                      ldo_mode_pkg::source_index) begin
            s_axi_rdata <= {24'h00_0000,
                            regulator_sequencer_source_select};
         end else if (s_axi_araddr[9:2] ==
                      ldo_mode_pkg::status_index) begin
            s_axi_rdata <= {24'h00_0000, regulator_low_power,
                            regulator_on};
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ldo_mode_pkg::resp_slverr;
         end
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------------

   // Channel 4 sits in the top field, channel 7 in the bottom one.
   // A mode of zero wins over every other input, so software can always
   // force a channel off whatever its sequencer is doing.
   always_comb begin
      logic [1:0] mode;
      logic [1:0] src;
      ldo_mode_pkg::reg_ctrl_t ctrl;
      mode = 2'h0;
      src  = 2'h0;
      ctrl = '0;
      next_on        = 4'h0;
      next_low_power = 4'h0;
      for (int i = 0; i < 4; i++) begin
         mode = power_mode_control[7 - 2 * i -: 2];
         src  = regulator_sequencer_source_select[7 - 2 * i -: 2];
         ctrl = '0;
         if (mode == ldo_mode_pkg::mode_off) begin
            ctrl = '0;
         end else if (src == ldo_mode_pkg::source_register) begin
            ctrl.on = 1'b1;
            case (mode)
               ldo_mode_pkg::mode_group_lp: ctrl.low_power = glp_stable;
               ldo_mode_pkg::mode_low_power: ctrl.low_power = 1'b1;
               default: ctrl.low_power = 1'b0;
            endcase
         end else if (!seq_stable[i]) begin
            ctrl = '0;
         end else begin
            ctrl.on = 1'b1;
            case (mode)
               ldo_mode_pkg::mode_group_lp: ctrl.low_power = glp_stable;
               ldo_mode_pkg::mode_low_power: ctrl.low_power = 1'b1;
               default: ctrl.low_power = 1'b0;
            endcase
         end
         next_on[i]        = ctrl.on;
         next_low_power[i] = ctrl.low_power;
      end
   end

   // Control levels are registered so every change lands one edge later.
   // This also keeps decode glitches off the regulator control pins.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         regulator_on        <= 4'h0;
         regulator_low_power <= 4'h0;
      end else begin
         regulator_on        <= next_on;
         regulator_low_power <= next_low_power;
      end
   end

endmodule

// ------------------------------------------------------------------
// Input filter
// ------------------------------------------------------------------

// Three shift flops and an output flop per bit; the filtered level follows only where the second
// and third stages agree, so a level caught mid-change is never passed on.
// The cost is a latency of four edges from pin to filtered level.
module level_filter #(
   parameter int width = 1
) (
   // Clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // Raw level from a pin and its filtered copy
   input  wire logic [width-1:0] raw,
   output logic      [width-1:0] filtered
);

   logic [width-1:0] stage1;
   logic [width-1:0] stage2;
   logic [width-1:0] stage3;

   // Stages shift every edge; filtered bits load where two and three agree.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stage1   <= '0;
         stage2   <= '0;
         stage3   <= '0;
         filtered <= '0;
      end else begin
         stage1 <= raw;
         stage2 <= stage1;
         stage3 <= stage2;
         for (int i = 0; i < width; i++) begin
            if (stage2[i] == stage3[i]) begin
               filtered[i] <= stage3[i];
            end
         end
      end
   end

endmodule

// ### testbench/ldo_decode_monitor.sv
// Checker of the decoder's behaviour at its ports.
// Assumes it is bound to the decoder, its ports matching by name.
module ldo_decode_monitor (
   // Clock and reset
   input wire logic       aclk,
   input wire logic       aresetn,
   // Bus handshakes
   input wire logic       s_axi_awvalid,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_wvalid,
   input wire logic       s_axi_wready,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid,
   input wire logic       s_axi_rready,
   // Control inputs and regulator levels
   input wire logic [3:0] sequencer_enable,
   input wire logic       global_low_power,
   input wire logic [3:0] regulator_on,
   input wire logic [3:0] regulator_low_power
);
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------
   // Checks, all on the bus clock and idle during reset
   // ------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_lp_needs_on:
   assert property ((regulator_low_power & ~regulator_on) == 4'h0)
      else $error("low power on a disabled channel");
   a_steady_levels:
   assert property (($stable(sequencer_enable) && $stable(global_low_power)
      && !s_axi_bvalid) [*8] |-> $stable({regulator_on, regulator_low_power}))
      else $error("levels moved without a cause");
   a_write_answer:
   assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:3] s_axi_bvalid)
      else $error("write response late");
   a_read_answer:
   assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
      else $error("read data late");
   a_write_busy:
   assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_read_busy:
   assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   a_write_reopen:
   assert property (s_axi_bvalid && s_axi_bready
      |-> ##[1:3] (s_axi_awready && s_axi_wready))
      else $error("write side did not reopen");
   a_read_reopen:
   assert property (s_axi_rvalid && s_axi_rready |-> ##[1:2] s_axi_arready)
      else $error("read side did not reopen");
endmodule

bind ldo_power_mode_decode ldo_decode_monitor u_ldo_decode_monitor (.*);

// ### testbench/ldo_power_mode_decode_tb_top.sv
// Self-checking bench for the regulator power-mode decoder.
// Assumes the package, decoder and checker are compiled first.
module ldo_power_mode_decode_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, global_low_power;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid;
   logic [9:0]  s_axi_awaddr, s_axi_araddr;
   logic [7:0]  md, sr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rnd, got, lvl;
   logic [3:0]  s_axi_wstrb, sequencer_enable;
   logic [3:0]  regulator_on, regulator_low_power;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   int          err_count, total_checks;

   ldo_power_mode_decode u_ldo_power_mode_decode (.*);

   // Free-running 25 MHz clock.
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      total_checks++;
      if (seen !== want) begin
         err_count++;
         $display("wrong value at %0t: %h expected %h", $time, seen, want);
      end
   endtask

   task automatic wrap_up;
      if (err_count == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // One write; each channel is released once it has been taken.
   task automatic wr(input logic [9:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      int n;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
      end while (!s_axi_bvalid && n < 40);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 40) begin
         err_count++;
         wrap_up();
      end
   endtask

   // One read; data and response are taken at the answering edge.
   task automatic rd(input logic [9:0] a);
      int n;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
      end while (!s_axi_rvalid && n < 40);
      got = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 40) begin
         err_count++;
         wrap_up();
      end
   endtask

   // Expected status word {low_power, on} for given fields and inputs.
   function automatic logic [31:0] want_status(input logic [7:0] m,
      input logic [7:0] s, input logic [3:0] e, input logic g);
      logic [3:0] on, lp;
      logic [1:0] f;
      for (int i = 0; i < 4; i++) begin
         f = m[7-2*i -: 2];
         on[i] = f != 2'h0 && (s[7-2*i -: 2] == 2'h3 || e[i]);
         lp[i] = on[i] && (f == 2'h2 || (f == 2'h1 && g));
      end
      return {24'h0, lp, on};
   endfunction

   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
       s_axi_rready, global_low_power, sequencer_enable} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      err_count = 0;
      total_checks = 0;
      rnd = 32'h966f;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd(ldo_mode_pkg::power_mode_addr);
      chk(got, 32'h0);
      rd(10'h00c);
      chk(resp, 2'h2);
      chk(got, 32'h0);
      wr(10'h010, 32'h1, 4'hf);
      chk(resp, 2'h2);
      // Every mode under each source first, then random settings.
      for (int i = 0; i < 64; i++) begin
         rnd = lfsr(rnd);
         md = (i < 32) ? {4{i[1:0]}} : rnd[7:0];
         sr = (i < 32) ? (i[2] ? 8'hff : {4{i[4:3]}}) : rnd[15:8];
         @(posedge aclk);
         sequencer_enable <= (i < 32) ? i[3:0] ^ 4'h5 : rnd[19:16];
         global_low_power <= (i < 32) ? i[4] : rnd[20];
         wr(ldo_mode_pkg::power_mode_addr, {rnd[31:8], md}, 4'h1);
         chk(resp, 2'h0);
         wr(ldo_mode_pkg::source_addr, {24'h0, sr}, 4'h1);
         repeat (8) @(posedge aclk);
         lvl = want_status(md, sr, sequencer_enable, global_low_power);
         chk({24'h0, regulator_low_power, regulator_on}, lvl);
         rd(ldo_mode_pkg::status_addr);
         chk(got, lvl);
         rd(ldo_mode_pkg::power_mode_addr);
         chk(got, {24'h0, md});
         rd(ldo_mode_pkg::source_addr);
         chk(got, {24'h0, sr});
      end
      wr(ldo_mode_pkg::power_mode_addr, ~{24'h0, md}, 4'h0);
      rd(ldo_mode_pkg::power_mode_addr);
      chk(got, {24'h0, md});
      wr(ldo_mode_pkg::status_addr, 32'hff, 4'hf);
      chk(resp, 2'h0);
      wrap_up();
   end
endmodule
